// ==== hdl/nu_feature_pkg.sv ====
// constants, formats and register map for the noise update feature tracker
package nu_feature_pkg;

   // number formats: levels Q8.8 signed, correlations Q1.15 signed, averages Q0.16 unsigned
   localparam int DB_W   = 16;
   localparam int CORR_W = 16;
   localparam int AVG_W  = 16;
   localparam int STA_W  = 32;
   localparam int CNT_W  = 16;
   localparam int INI_W  = 8;
   localparam int NUP_W  = 3;
   localparam int ADDR_W = 6;

   // residual spectrum and sub-band geometry
   localparam int SPEC_BINS  = 128;
   localparam int HF_BINS    = 40;
   localparam int BIN_IDX_W  = 7;
   localparam int BAND_IDX_W = 5;
   localparam int BAND_LO    = 2;
   localparam int BAND_HI    = 16;
   localparam int HF_SUM_W   = 22;
   localparam int CLOSE_W    = 21;

   // high-band dynamic recursion, coefficients in Q0.16
   localparam logic [16:0] HF_DECAY_Q16 = 17'h0B333;   // 0.7
   localparam logic [16:0] HF_MEAN_Q16  = 17'h001EC;   // 0.3 / 40
   localparam logic signed [DB_W-1:0] HF_LOW_DB  = 16'sh099A;  // 9.6 dB
   localparam logic signed [16:0]     HF_RISE_DB = 17'sh00480; // 4.5 dB

   // noise update state counter
   localparam logic [NUP_W-1:0] NUP_INIT = 3'h6;
   localparam logic [NUP_W-1:0] NUP_MAX  = 3'h6;
   localparam logic [NUP_W-1:0] NUP_UP   = 3'h2;
   localparam logic [NUP_W-1:0] NUP_DOWN = 3'h1;

   // increment-decision thresholds per bandwidth
   localparam logic [STA_W-1:0]  STA_THR_WB   = 32'h0005_5730;  // 350000
   localparam logic [STA_W-1:0]  STA_THR_NB   = 32'h0007_A120;  // 500000
   localparam logic [CORR_W-1:0] CORR_THR_WB  = 16'h6CCD;       // 0.85
   localparam logic [CORR_W-1:0] CORR_THR_NB  = 16'h599A;       // 0.7
   localparam logic [DB_W-1:0]   RESID_THR_WB = 16'h019A;       // 1.6
   localparam logic [DB_W-1:0]   RESID_THR_NB = 16'h0A66;       // 10.4

   // initialisation phase and closeness reference log(0.0035 + 1) in Q8.8
   localparam logic [INI_W-1:0]     INI_FRAMES   = 8'h64;  // 100
   localparam logic [INI_W-1:0]     INI_EVENT    = 8'h0A;  // 10
   localparam logic signed [DB_W-1:0] LOG_EMIN_REF = 16'sh0001;

   // harmonic event counter limits
   localparam logic signed [16:0] CORR_EVENT_X2 = 17'sh0D99A;  // 2 x 0.85
   localparam logic signed [16:0] E_LOW_DB      = 17'sh00F00;  // 15.0
   localparam logic signed [16:0] E_JUMP_DB     = 17'sh00700;  // 7.0
   localparam logic signed [16:0] E_HIGH_DB     = 17'sh01E00;  // 30.0
   localparam logic signed [16:0] E_VAR_LIM     = 17'sh00800;  // 8.0
   localparam logic [CNT_W-1:0]   HARM_ONE      = 16'h0001;
   localparam logic [CNT_W-1:0]   HARM_FOUR     = 16'h0004;
   localparam int                 HARM_SHIFT    = 2;

   // event occurrence average, Q0.16
   localparam logic [16:0]      EV_UP_Q16   = 17'h007AE;  // 0.03
   localparam logic [16:0]      EV_DOWN_Q16 = 17'h0028F;  // 0.01
   localparam logic [AVG_W-1:0] EV_ONE      = 16'hFFFF;

   // pause detector
   localparam logic signed [16:0]     PAUSE_GAP_DB = 17'sh00500;  // 5
   localparam logic signed [CNT_W-1:0] PAUSE_ACT   = 16'shFFFF;   // -1
   localparam logic signed [CNT_W-1:0] PAUSE_MAX   = 16'sh7FFF;

   // register map, byte addresses
   localparam logic [ADDR_W-1:0] REG_CTRL   = 6'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 6'h04;
   localparam logic [ADDR_W-1:0] REG_HFDYN  = 6'h08;
   localparam logic [ADDR_W-1:0] REG_HARM   = 6'h0C;
   localparam logic [ADDR_W-1:0] REG_PAUSE  = 6'h10;
   localparam logic [ADDR_W-1:0] REG_CLOSE  = 6'h14;
   localparam int CTRL_WIDEBAND = 0;
   localparam logic CTRL_RESET_VAL = 1'b1;

endpackage

// ==== hdl/window_sum.sv ====
// per-frame accumulator of samples whose index falls in a fixed window
`timescale 1ns/1ps
module window_sum #(
   parameter int IDX_W   = 7,
   parameter int VAL_W   = 16,
   parameter int SUM_W   = 22,
   parameter int LO      = 0,
   parameter int HI      = 0,
   parameter bit USE_ABS = 1'b0
) (
   // clock and control
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   input  wire logic                    ce,
   input  wire logic                    clear,
   // sample stream
   input  wire logic                    in_valid,
   input  wire logic [IDX_W-1:0]        in_index,
   input  wire logic signed [VAL_W-1:0] in_value,
   // running sum
   output logic signed [SUM_W-1:0]      sum_q
);
   logic                    in_window;
   logic signed [VAL_W-1:0] term;
   logic signed [SUM_W-1:0] sum_d;

   assign in_window = (int'(in_index) >= LO) && (int'(in_index) <= HI);
   assign term      = (USE_ABS && in_value < 0) ? -in_value : in_value;
   // clear beats a same-cycle sample: the frame strobe closes the frame
   assign sum_d     = clear ? '0 :
                      (in_valid && in_window) ? sum_q + SUM_W'(term) : sum_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sum_q <= '0;
      end else if (ce) begin
         sum_q <= sum_d;
      end
   end
endmodule

// ==== hdl/noise_update_feature_tracker.sv ====
// frame-rate features feeding the background noise update decision
`timescale 1ns/1ps
module noise_update_feature_tracker
   import nu_feature_pkg::*;
(
   // clock, reset, enable
   input  wire logic                              clk,
   input  wire logic                              sys_rst,
   input  wire logic                              ce,
   // avalon-mm slave
   input  wire logic [nu_feature_pkg::ADDR_W-1:0] address,
   input  wire logic                              read,
   input  wire logic                              write,
   input  wire logic [31:0]                       writedata,
   input  wire logic [3:0]                        byteenable,
   output logic [31:0]                            readdata,
   output logic                                   waitrequest,
   // residual spectrum bin stream
   input  wire logic                              bin_valid,
   input  wire logic [nu_feature_pkg::BIN_IDX_W-1:0] bin_index,
   input  wire logic signed [nu_feature_pkg::DB_W-1:0] residual_log_spectrum,
   // sub-band stream, log(E+1) of band energy and previous noise estimate
   input  wire logic                              band_valid,
   input  wire logic [nu_feature_pkg::BAND_IDX_W-1:0] band_index,
   input  wire logic signed [nu_feature_pkg::DB_W-1:0] band_log_energy,
   input  wire logic signed [nu_feature_pkg::DB_W-1:0] band_log_noise,
   // per-frame scalars, taken with frame_valid
   input  wire logic                              frame_valid,
   input  wire logic                              nup_active,
   input  wire logic signed [nu_feature_pkg::CORR_W-1:0] corr_half0,
   input  wire logic signed [nu_feature_pkg::CORR_W-1:0] corr_half1,
   input  wire logic [nu_feature_pkg::DB_W-1:0]   corr_map_sum,
   input  wire logic [nu_feature_pkg::DB_W-1:0]   tonal_threshold,
   input  wire logic                              strong_peak,
   input  wire logic signed [nu_feature_pkg::DB_W-1:0] frame_energy,
   input  wire logic signed [nu_feature_pkg::DB_W-1:0] longterm_avg_energy,
   input  wire logic signed [nu_feature_pkg::DB_W-1:0] longterm_min_energy,
   input  wire logic signed [nu_feature_pkg::DB_W-1:0] energy_variance,
   // features toward the update decision logic
   output logic [nu_feature_pkg::STA_W-1:0]       stationarity_threshold,
   output logic [nu_feature_pkg::CORR_W-1:0]      correlation_threshold,
   output logic [nu_feature_pkg::DB_W-1:0]        residual_threshold,
   output logic signed [nu_feature_pkg::DB_W-1:0] high_band_dynamic,
   output logic                                   high_band_range_flag,
   output logic                                   noise_update_allowed,
   output logic                                   tonal_flag,
   output logic [nu_feature_pkg::CLOSE_W-1:0]     closeness,
   output logic [nu_feature_pkg::CNT_W-1:0]       harmonic_count,
   output logic [nu_feature_pkg::AVG_W-1:0]       event_occurrence_average,
   output logic signed [nu_feature_pkg::CNT_W-1:0] pause_counter,
   output logic                                   frame_done
);
   import nu_feature_pkg::*;

   // ---------------- state
   logic                     wideband_q;
   logic signed [DB_W-1:0]   dyn_q, ref_q;
   logic                     flag_q;
   logic [NUP_W-1:0]         nup_q;
   logic [INI_W-1:0]         ini_q;
   logic [CNT_W-1:0]         harm_q;
   logic [AVG_W-1:0]         avg_q;
   logic signed [CNT_W-1:0]  pause_q;
   logic [CLOSE_W-1:0]       close_q;
   logic                     tonal_q, allow_q, done_q, wait_q;
   logic [31:0]              rdata_q;
   logic [STA_W-1:0]         sta_thr_q;
   logic [CORR_W-1:0]        corr_thr_q;
   logic [DB_W-1:0]          resid_thr_q;

   logic                     frame;
   assign frame = ce && frame_valid;

   // ---------------- accumulators, cleared by the frame strobe
   logic signed [HF_SUM_W-1:0] hf_sum;
   logic signed [CLOSE_W-1:0]  close_sum;
   logic signed [16:0]         band_diff;
   logic                       init_phase;
   logic signed [DB_W-1:0]     band_ref;

   assign init_phase = ini_q < INI_FRAMES;
   assign band_ref   = init_phase ? LOG_EMIN_REF : band_log_noise;
   assign band_diff  = 17'(band_log_energy) - 17'(band_ref);

   window_sum #(
      .IDX_W   (BIN_IDX_W),
      .VAL_W   (DB_W),
      .SUM_W   (HF_SUM_W),
      .LO      (SPEC_BINS - HF_BINS),
      .HI      (SPEC_BINS - 1),
      .USE_ABS (1'b0)
   ) u_hf_sum (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .ce       (ce),
      .clear    (frame_valid),
      .in_valid (bin_valid),
      .in_index (bin_index),
      .in_value (residual_log_spectrum),
      .sum_q    (hf_sum)
   );

   // same sub-bands regardless of bandwidth
   window_sum #(
      .IDX_W   (BAND_IDX_W),
      .VAL_W   (17),
      .SUM_W   (CLOSE_W),
      .LO      (BAND_LO),
      .HI      (BAND_HI),
      .USE_ABS (1'b1)
   ) u_close_sum (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .ce       (ce),
      .clear    (frame_valid),
      .in_valid (band_valid),
      .in_index (band_index),
      .in_value (band_diff),
      .sum_q    (close_sum)
   );

   // ---------------- high-band dynamic and its flag
   logic signed [39:0]     hf_acc;
   logic signed [DB_W-1:0] dyn_d;
   logic signed [16:0]     dyn_rise;
   logic                   hf_clr, hf_set;

   // 0.3/40 folded into one coefficient so no divider is needed
   assign hf_acc   = 40'($signed(dyn_q) * $signed(HF_DECAY_Q16))
                   + 40'($signed(hf_sum) * $signed(HF_MEAN_Q16));
   assign dyn_d    = hf_acc[31:16];
   assign dyn_rise = 17'(dyn_d) - 17'(ref_q);
   assign hf_clr   = (dyn_d < HF_LOW_DB) && flag_q;
   assign hf_set   = !hf_clr && (dyn_rise > HF_RISE_DB);

   // ---------------- noise update state counter
   logic [NUP_W-1:0] nup_d;
   assign nup_d = nup_active ? ((nup_q >= NUP_MAX - NUP_UP) ? NUP_MAX : nup_q + NUP_UP)
                : ((nup_q == '0) ? '0 : nup_q - NUP_DOWN);

   // ---------------- harmonic event counter and occurrence average
   logic signed [16:0] corr_pair, gap_avg, gap_min, energy_x, var_x;
   logic               tonal_d, event_hit, big_jump;
   logic [CNT_W-1:0]   harm_1, harm_2, harm_d;

   assign corr_pair = 17'(corr_half0) + 17'(corr_half1);
   assign energy_x  = 17'(frame_energy);
   assign var_x     = 17'(energy_variance);
   assign gap_avg   = energy_x - 17'(longterm_avg_energy);
   assign gap_min   = energy_x - 17'(longterm_min_energy);
   assign tonal_d   = (corr_map_sum > tonal_threshold) || strong_peak;
   assign event_hit = (corr_pair > CORR_EVENT_X2) || tonal_d;
   assign big_jump  = (ini_q > INI_EVENT) && (gap_avg > E_JUMP_DB);
   assign harm_1    = event_hit ? '0 : ((&harm_q) ? harm_q : harm_q + HARM_ONE);
   assign harm_2    = (harm_1 > HARM_ONE && (energy_x < E_LOW_DB || big_jump))
                    ? HARM_ONE : harm_1;
   assign harm_d    = (harm_2 > HARM_ONE && energy_x > E_HIGH_DB && var_x > E_VAR_LIM)
                    ? ((harm_2 < HARM_FOUR) ? HARM_ONE : (harm_2 >> HARM_SHIFT))
                    : harm_2;

   logic [AVG_W-1:0]   ev_target;
   logic [16:0]        ev_coef;
   logic signed [16:0] ev_diff;
   logic signed [33:0] ev_step;
   logic signed [16:0] ev_sum;
   logic [AVG_W-1:0]   avg_d;

   assign ev_target = (harm_d == '0) ? EV_ONE : '0;
   assign ev_coef   = (harm_d == '0) ? EV_UP_Q16 : EV_DOWN_Q16;
   assign ev_diff   = $signed({1'b0, ev_target}) - $signed({1'b0, avg_q});
   assign ev_step   = ev_diff * $signed(ev_coef);
   // floor of the step keeps the average inside 0..1 in both directions
   assign ev_sum    = $signed({1'b0, avg_q}) + ev_step[32:16];
   assign avg_d     = ev_sum[AVG_W-1:0];

   // ---------------- energy pause detector, steps in order
   logic signed [CNT_W-1:0] pause_1, pause_2, pause_d;
   assign pause_1 = (!pause_q[CNT_W-1] && gap_min > PAUSE_GAP_DB) ? PAUSE_ACT : pause_q;
   assign pause_2 = (pause_1 == PAUSE_ACT && gap_min < PAUSE_GAP_DB) ? '0 : pause_1;
   assign pause_d = (!pause_2[CNT_W-1] && pause_2 != PAUSE_MAX) ? pause_2 + 16'sh0001
                  : pause_2;

   // ---------------- frame state
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dyn_q   <= '0;
         ref_q   <= '0;
         flag_q  <= 1'b0;
         nup_q   <= NUP_INIT;
         ini_q   <= '0;
         harm_q  <= '0;
         avg_q   <= '0;
         pause_q <= '0;
         close_q <= '0;
         tonal_q <= 1'b0;
         allow_q <= 1'b0;
         done_q  <= 1'b0;
      end else if (ce) begin
         done_q <= frame_valid;
         if (frame_valid) begin
            dyn_q <= dyn_d;
            if (hf_clr) begin
               flag_q <= 1'b0;
               ref_q  <= dyn_d;
            end else if (hf_set) begin
               flag_q <= 1'b1;                                         // no else: both hold
            end
            nup_q   <= nup_d;
            allow_q <= (nup_d == '0);
            ini_q   <= (&ini_q) ? ini_q : ini_q + 8'h01;
            harm_q  <= harm_d;
            avg_q   <= avg_d;
            pause_q <= pause_d;
            close_q <= close_sum[CLOSE_W-1:0];
            tonal_q <= tonal_d;
         end
      end
   end

   // ---------------- avalon-mm slave, one wait state per access
   logic [31:0] rd_mux;
   logic        req, take;
   assign req  = read || write;
   assign take = req && !wait_q;

   function automatic logic [31:0] reg_read(input logic [ADDR_W-1:0] a);
      case (a)
         REG_CTRL:   reg_read = {31'h0, wideband_q};
         REG_STATUS: reg_read = {23'h0, tonal_q, 1'b0, nup_q, 2'h0, allow_q, flag_q};
         REG_HFDYN:  reg_read = {ref_q, dyn_q};
         REG_HARM:   reg_read = {avg_q, harm_q};
         REG_PAUSE:  reg_read = {8'h00, ini_q, pause_q};
         REG_CLOSE:  reg_read = {11'h000, close_q};
         default:    reg_read = 32'h0000_0000;
      endcase
   endfunction
   assign rd_mux = reg_read(address);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wait_q     <= 1'b1;
         rdata_q    <= '0;
         wideband_q <= CTRL_RESET_VAL;
      end else if (ce) begin
         // waitrequest drops for exactly one cycle after a request shows
         wait_q <= !(req && wait_q);
         if (read && wait_q) begin
            rdata_q <= rd_mux;
         end
         if (write && take && address == REG_CTRL && byteenable[0]) begin
            wideband_q <= writedata[CTRL_WIDEBAND];
         end
      end
   end

   // ---------------- threshold selection
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sta_thr_q   <= STA_THR_WB;
         corr_thr_q  <= CORR_THR_WB;
         resid_thr_q <= RESID_THR_WB;
      end else if (ce) begin
         sta_thr_q   <= wideband_q ? STA_THR_WB : STA_THR_NB;
         corr_thr_q  <= wideband_q ? CORR_THR_WB : CORR_THR_NB;
         resid_thr_q <= wideband_q ? RESID_THR_WB : RESID_THR_NB;
      end
   end

   // ---------------- outputs
   assign readdata                 = rdata_q;
   assign waitrequest              = wait_q;
   assign stationarity_threshold   = sta_thr_q;
   assign correlation_threshold    = corr_thr_q;
   assign residual_threshold       = resid_thr_q;
   assign high_band_dynamic        = dyn_q;
   assign high_band_range_flag     = flag_q;
   assign noise_update_allowed     = allow_q;
   assign tonal_flag               = tonal_q;
   assign closeness                = close_q;
   assign harmonic_count           = harm_q;
   assign event_occurrence_average = avg_q;
   assign pause_counter            = pause_q;
   assign frame_done               = done_q;

   // ---------------- assertions
   nup_range_a: assert property (@(posedge clk) disable iff (sys_rst)
      nup_q <= NUP_MAX) else $error("update counter above its bound");

   nup_rise_a: assert property (@(posedge clk) disable iff (sys_rst)
      (frame && nup_active && nup_q <= NUP_MAX - NUP_UP) |=> nup_q == $past(nup_q) + NUP_UP)
      else $error("update counter did not rise by two");

   nup_fall_a: assert property (@(posedge clk) disable iff (sys_rst)
      (frame && !nup_active && nup_q != '0) |=> nup_q == $past(nup_q) - NUP_DOWN)
      else $error("update counter did not fall by one");

   allow_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
      frame |=> (noise_update_allowed == (nup_q == '0)))
      else $error("update permission not tied to zero count");

   flag_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      (frame && !hf_clr && !hf_set) |=> $stable(flag_q) && $stable(ref_q))
      else $error("range flag or reference moved without cause");

   harm_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      (frame && (corr_pair > CORR_EVENT_X2 || strong_peak)) |=> harm_q == '0 && (tonal_q || !$past(strong_peak)))
      else $error("harmonic counter not cleared on event");

   pause_enter_a: assert property (@(posedge clk) disable iff (sys_rst)
      (frame && !pause_q[CNT_W-1] && gap_min > PAUSE_GAP_DB) |=> pause_q == PAUSE_ACT)
      else $error("pause detector missed activity");

   pause_count_a: assert property (@(posedge clk) disable iff (sys_rst)
      (frame && !pause_q[CNT_W-1] && gap_min <= PAUSE_GAP_DB && pause_q != PAUSE_MAX)
      |=> pause_q == $past(pause_q) + 16'sh0001) else $error("pause count did not advance");

   bus_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && req && waitrequest) |=> !waitrequest ##1 (waitrequest || !ce))
      else $error("waitrequest not a single low cycle");

   thr_pick_a: assert property (@(posedge clk) disable iff (sys_rst)
      (ce && !wideband_q) ##1 ce |-> stationarity_threshold == STA_THR_NB)
      else $error("narrowband threshold not selected");

endmodule

// ==== verif/frontend_model.sv ====
// residual bin and sub-band streamer standing in for the spectral front end
`timescale 1ns/1ps
module frontend_model (
   // control from the bench
   input  wire logic        clk,
   input  wire logic        start,
   input  wire logic [15:0] bin_v,
   input  wire logic [15:0] band_e,
   input  wire logic [15:0] band_n,
   // streams into the tracker
   output logic             bin_valid,
   output logic [6:0]       bin_index,
   output logic [15:0]      residual_log_spectrum,
   output logic             band_valid,
   output logic [4:0]       band_index,
   output logic [15:0]      band_log_energy,
   output logic [15:0]      band_log_noise
);
   logic [5:0] k_q = 6'h3F;
   wire        busy = (k_q != 6'h3F);
   always_ff @(posedge clk) begin
      if (start) k_q <= 6'h00;
      else if (busy) k_q <= (k_q == 6'h39) ? 6'h3F : k_q + 6'h01;
   end
   // 40 top bins then bands 0..17, outer bands must be ignored; idle lines show inverted data
   assign bin_valid = (k_q < 6'h28);
   assign bin_index = 7'h58 + 7'(k_q);
   assign residual_log_spectrum = bin_valid ? bin_v : ~bin_v;
   assign band_valid = busy && !bin_valid;
   assign band_index = 5'(k_q - 6'h28);
   assign band_log_energy = band_valid ? band_e : ~band_e;
   assign band_log_noise = band_valid ? band_n : ~band_n;
endmodule

// ==== verif/tb_top.sv ====
// self-checking bench for the noise update feature tracker
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_top;
   import nu_feature_pkg::*;
   logic clk = 0, sys_rst = 1, ce = 1, read = 0, write = 0, frame_valid = 0, nup_active = 0, strong_peak = 0, start = 0;
   logic [5:0] address = 0;
   logic [31:0] writedata = 0, readdata, q, stationarity_threshold;
   logic [3:0] byteenable = 4'hF;
   logic [15:0] bv = 0, band_e = 0, band_n = 0, corr_half0 = 0, corr_half1 = 0, corr_map_sum = 0, tonal_threshold = 0;
   logic [15:0] frame_energy = 0, longterm_avg_energy = 0, longterm_min_energy = 0, energy_variance = 0;
   logic [15:0] residual_log_spectrum, band_log_energy, band_log_noise, correlation_threshold, residual_threshold;
   logic signed [15:0] high_band_dynamic, pause_counter;
   logic [15:0] harmonic_count, event_occurrence_average;
   logic [20:0] closeness;
   logic [6:0] bin_index;
   logic [4:0] band_index;
   logic waitrequest, bin_valid, band_valid, high_band_range_flag, noise_update_allowed, tonal_flag, frame_done;
   logic wb = 1, fl = 0, ev, a, pk;
   int i, t, c, m, tt, f, j, d, v, e, n, r, nq = 6, pc = 0, hc = 0, n_mismatch = 0, n_compared = 0;
   real dm = 0, rf = 0, ea = 0, x, y;
   logic [15:0] tbl [8] = '{16'h2800, 0, 0, 0, 16'h1E00, 16'h1E00, 0, 0};
   noise_update_feature_tracker uut (.clk, .sys_rst, .ce, .address, .read, .write, .writedata, .byteenable,
      .readdata, .waitrequest, .bin_valid, .bin_index, .residual_log_spectrum, .band_valid, .band_index,
      .band_log_energy, .band_log_noise, .frame_valid, .nup_active, .corr_half0, .corr_half1, .corr_map_sum,
      .tonal_threshold, .strong_peak, .frame_energy, .longterm_avg_energy, .longterm_min_energy, .energy_variance,
      .stationarity_threshold, .correlation_threshold, .residual_threshold, .high_band_dynamic,
      .high_band_range_flag, .noise_update_allowed, .tonal_flag, .closeness, .harmonic_count,
      .event_occurrence_average, .pause_counter, .frame_done);
   frontend_model fe_m (.clk, .start, .bin_v(bv), .band_e, .band_n, .bin_valid, .bin_index,
      .residual_log_spectrum, .band_valid, .band_index, .band_log_energy, .band_log_noise);
   always #12.5 clk = ~clk;
   function automatic int nup_f(int k, logic up);
      return up ? (k > 4 ? 6 : k + 2) : (k > 0 ? k - 1 : 0);
   endfunction
   function automatic int pause_f(int p, int gap);
      if (p >= 0 && gap > 1280) p = -1;
      if (p == -1 && gap < 1280) p = 0;
      return p >= 0 ? p + 1 : p;
   endfunction
   function automatic int harm_f(int h, logic hit, int en, int jmp, int var_e);
      h = hit ? 0 : h + 1;
      if (h > 1 && (en < 3840 || jmp > 1792)) h = 1;
      if (h > 1 && en > 7680 && var_e > 2048) h = h < 4 ? 1 : h / 4;
      return h;
   endfunction
   task automatic report_and_stop;
      if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // holds the request until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] dat, output logic [31:0] rd);
      @(posedge clk) begin read <= !w; write <= w; address <= ad; writedata <= dat; end
      t = 0;
      do begin @(posedge clk); t++; end while (waitrequest !== 1'b0 && t < 40);
      rd = readdata;
      read <= 0;
      write <= 0;
      if (t >= 40) n_mismatch++;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      void'($urandom(5611));
      repeat (3) @(posedge clk);
      sys_rst <= 0;
      bus(0, 6'h3C, 0, q);
      `CHK("unmapped", 32'h0, q)
      for (i = 0; i < 118; i++) begin
         if (i == 60) begin bus(1, REG_CTRL, 0, q); wb = 0; end
         e = $urandom_range(0, 4095); n = $urandom_range(0, 4095);
         @(posedge clk) begin start <= 1; bv <= i < 8 ? tbl[i] : 16'h0; band_e <= 16'(e); band_n <= 16'(n); end
         @(posedge clk) start <= 0;
         repeat (58) @(posedge clk);
         a = ($urandom_range(0, 3) == 0); c = $urandom_range(16'h4000, 16'h7FFF); m = $urandom_range(0, 60);
         tt = $urandom_range(49, 60); pk = ($urandom_range(0, 9) == 0); f = $urandom_range(0, 40) * 256;
         j = i < 12 ? 0 : $urandom_range(0, 10) * 256; d = $urandom_range(0, 10) * 256; v = $urandom_range(4, 12) * 256;
         frame_valid <= 1; nup_active <= a; corr_half0 <= 16'(c); corr_half1 <= 16'(c);
         corr_map_sum <= 16'(m); tonal_threshold <= 16'(tt); strong_peak <= pk; frame_energy <= 16'(f);
         longterm_avg_energy <= 16'(f - j); longterm_min_energy <= 16'(f - d); energy_variance <= 16'(v);
         @(posedge clk) frame_valid <= 0;
         @(negedge clk);
         ev = (2 * c > 'hD99A) || (m > tt) || pk;
         hc = harm_f(hc, ev, f, j, v); nq = nup_f(nq, a); pc = pause_f(pc, d);
         ea = ev ? ea + 0.03 * (1.0 - ea) : ea * 0.99;
         dm = 0.7 * dm + 0.3 * ((i < 8 ? $signed(tbl[i]) : 0) / 256.0);
         if (dm < 9.6 && fl) begin fl = 0; rf = dm; end
         else if (dm - rf > 4.5) fl = 1;
         x = high_band_dynamic / 256.0 - dm; y = event_occurrence_average / 65536.0 - ea; r = i < 100 ? 1 : n;
         `CHK("done", 1'b1, frame_done)
         `CHK("dyn", 1'b1, x < 0.1 && x > -0.1)
         `CHK("flag", fl, high_band_range_flag)
         `CHK("upd_ok", nq == 0, noise_update_allowed)
         `CHK("thr", wb ? {STA_THR_WB, CORR_THR_WB, RESID_THR_WB} : {STA_THR_NB, CORR_THR_NB, RESID_THR_NB}, {stationarity_threshold, correlation_threshold, residual_threshold})
         `CHK("close", 21'(15 * (e > r ? e - r : r - e)), closeness)
         `CHK("harm", 16'(hc), harmonic_count)
         `CHK("avg", 1'b1, y < 0.01 && y > -0.01)
         `CHK("tonal", (m > tt) || pk, tonal_flag)
         `CHK("pause", 16'(pc), pause_counter)
      end
      // frame strobe with the enable low must leave frame_done, the pause counter and the harmonic count frozen
      @(posedge clk) begin ce <= 0; frame_valid <= 1; end
      @(posedge clk) frame_valid <= 0;
      @(negedge clk);
      `CHK("frozen_done", 1'b0, frame_done)
      `CHK("frozen_pause", 16'(pc), pause_counter)
      `CHK("frozen_harm", 16'(hc), harmonic_count)
      @(posedge clk) ce <= 1;
      byteenable <= 4'h0;
      bus(1, REG_CTRL, 32'h0000_0001, q);
      byteenable <= 4'hF;
      bus(0, REG_CTRL, 0, q);
      `CHK("ctrl", {31'h0, wb}, q)
      bus(0, REG_HARM, 0, q);
      `CHK("harm_reg", 16'(hc), q[15:0])
      bus(0, REG_PAUSE, 0, q);
      `CHK("pause_reg", {8'h76, 16'(pc)}, q[23:0])
      bus(0, REG_CLOSE, 0, q);
      `CHK("close_reg", 32'(15 * (e > n ? e - n : n - e)), q)
      bus(0, REG_STATUS, 0, q);
      `CHK("status", {3'(nq), nq == 0, fl}, {q[6:4], q[1:0]})
      report_and_stop();
   end
endmodule
